// ==== mroe_exec.sv ====
// execution sequencer for jump, move, or, return and rotate instructions
`timescale 1ns/1ps
module mroe_exec #(
  parameter int unsigned MEM_DEPTH = 256
) (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_nrst,
  input  wire logic                          i_valid,
  input  wire mroe_pkg::mroe_op_t            i_op,
  input  wire logic [mroe_pkg::PC_W-1:0]     i_operand,
  input  wire logic                          i_irq_pending,
  input  wire logic [mroe_pkg::PC_W-1:0]     i_stack_top,
  output logic                               o_ready,
  output logic [mroe_pkg::PC_W-1:0]          o_pc,
  output logic [mroe_pkg::DATA_W-1:0]        o_acc,
  output logic                               o_zero,
  output logic                               o_irq_enable,
  output logic                               o_stack_pop,
  output logic                               o_irq_taken
);
  mroe_mem_if mem_bus ();

  mroe_pkg::mroe_state_t             state_reg;
  mroe_pkg::mroe_state_t             state_next;
  mroe_pkg::mroe_op_t                pend_op_reg;
  mroe_pkg::mroe_op_t                pend_op_next;
  logic [mroe_pkg::ADDR_W-1:0]       maddr_reg;
  logic [mroe_pkg::ADDR_W-1:0]       maddr_next;
  logic [mroe_pkg::PC_W-1:0]         pc_reg;
  logic [mroe_pkg::PC_W-1:0]         pc_next;
  logic [mroe_pkg::DATA_W-1:0]       accumulator_reg;
  logic [mroe_pkg::DATA_W-1:0]       accumulator_next;
  logic                              zero_reg;
  logic                              zero_next;
  logic                              master_irq_enable_reg;
  logic                              master_irq_enable_next;
  logic                              ready_reg;
  logic                              ready_next;
  logic                              pop_reg;
  logic                              pop_next;
  logic                              taken_reg;
  logic                              taken_next;
  logic                              accept;
  logic [mroe_pkg::DATA_W-1:0]       literal;
  logic [mroe_pkg::DATA_W-1:0]       mem_byte;
  logic [mroe_pkg::DATA_W-1:0]       or_result;
  logic [mroe_pkg::DATA_W-1:0]       rot_result;

  mroe_dmem #(
    .DEPTH (MEM_DEPTH)
  ) u_dmem (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .bus       (mem_bus.store)
  );

  // operand views and datapath results
  assign accept     = ready_reg & i_valid;
  assign literal    = i_operand[mroe_pkg::DATA_W-1:0];
  assign mem_byte   = mem_bus.rdata;
  assign or_result  = accumulator_reg | mem_byte;
  assign rot_result = {mem_byte[mroe_pkg::ROT_MSB-1:0],
                       mem_byte[mroe_pkg::ROT_MSB]};

  // next-state and datapath decisions
  always_comb begin
    state_next             = state_reg;
    pend_op_next           = pend_op_reg;
    maddr_next             = maddr_reg;
    pc_next                = pc_reg;
    accumulator_next       = accumulator_reg;
    zero_next              = zero_reg;
    master_irq_enable_next = master_irq_enable_reg;
    pop_next               = 1'b0;
    taken_next             = 1'b0;
    mem_bus.addr           = maddr_reg;
    mem_bus.re             = 1'b0;
    mem_bus.we             = 1'b0;
    mem_bus.wdata          = accumulator_reg;
    case (state_reg)
      mroe_pkg::st_idle: begin
        if (accept) begin
          pc_next = pc_reg + mroe_pkg::PC_STEP;
          case (i_op)
            mroe_pkg::jump_op: begin
              pc_next    = i_operand;
              state_next = mroe_pkg::st_dummy;
            end
            mroe_pkg::load_mem_op,
            mroe_pkg::or_mem_op,
            mroe_pkg::or_into_memory_op,
            mroe_pkg::rotate_left_op: begin
              mem_bus.addr = i_operand[mroe_pkg::ADDR_W-1:0];
              mem_bus.re   = 1'b1;
              maddr_next   = i_operand[mroe_pkg::ADDR_W-1:0];
              pend_op_next = i_op;
              state_next   = mroe_pkg::st_mem;
            end
            mroe_pkg::load_lit_op: begin
              accumulator_next = literal;
            end
            mroe_pkg::store_acc_op: begin
              mem_bus.addr = i_operand[mroe_pkg::ADDR_W-1:0];
              mem_bus.we   = 1'b1;
            end
            mroe_pkg::or_lit_op: begin
              accumulator_next = accumulator_reg | literal;
              zero_next = ((accumulator_reg | literal)
                           == mroe_pkg::DATA_ZERO);
            end
            mroe_pkg::return_op: begin
              pc_next  = i_stack_top;
              pop_next = 1'b1;
            end
            mroe_pkg::return_lit_op: begin
              pc_next          = i_stack_top;
              pop_next         = 1'b1;
              accumulator_next = literal;
            end
            mroe_pkg::interrupt_return_op: begin
              if (i_irq_pending) begin
                // return address stays on the stack for the handler
                pc_next    = mroe_pkg::IRQ_VECTOR;
                taken_next = 1'b1;
                master_irq_enable_next = 1'b0;
              end else begin
                pc_next  = i_stack_top;
                pop_next = 1'b1;
                master_irq_enable_next = 1'b1;
              end
            end
            default: begin
              pc_next = pc_reg + mroe_pkg::PC_STEP;
            end
          endcase
        end
      end
      mroe_pkg::st_mem: begin
        state_next = mroe_pkg::st_idle;
        case (pend_op_reg)
          mroe_pkg::load_mem_op: begin
            accumulator_next = mem_byte;
          end
          mroe_pkg::or_mem_op: begin
            accumulator_next = or_result;
            zero_next = (or_result == mroe_pkg::DATA_ZERO);
          end
          mroe_pkg::or_into_memory_op: begin
            mem_bus.we    = 1'b1;
            mem_bus.wdata = or_result;
            zero_next = (or_result == mroe_pkg::DATA_ZERO);
          end
          mroe_pkg::rotate_left_op: begin
            mem_bus.we    = 1'b1;
            mem_bus.wdata = rot_result;
          end
          default: begin
            state_next = mroe_pkg::st_idle;
          end
        endcase
      end
      mroe_pkg::st_dummy: begin
        state_next = mroe_pkg::st_idle;
      end
      default: begin
        state_next = mroe_pkg::st_idle;
      end
    endcase
    ready_next = (state_next == mroe_pkg::st_idle);
  end

  // state registers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg             <= mroe_pkg::st_idle;
      pend_op_reg           <= mroe_pkg::nop_op;
      maddr_reg             <= '0;
      pc_reg                <= mroe_pkg::PC_RESET;
      accumulator_reg       <= mroe_pkg::ACC_RESET;
      zero_reg              <= 1'b0;
      master_irq_enable_reg <= 1'b0;
      ready_reg             <= 1'b1;
      pop_reg               <= 1'b0;
      taken_reg             <= 1'b0;
    end else begin
      state_reg             <= state_next;
      pend_op_reg           <= pend_op_next;
      maddr_reg             <= maddr_next;
      pc_reg                <= pc_next;
      accumulator_reg       <= accumulator_next;
      zero_reg              <= zero_next;
      master_irq_enable_reg <= master_irq_enable_next;
      ready_reg             <= ready_next;
      pop_reg               <= pop_next;
      taken_reg             <= taken_next;
    end
  end

  // outputs straight from flops
  assign o_ready      = ready_reg;
  assign o_pc         = pc_reg;
  assign o_acc        = accumulator_reg;
  assign o_zero       = zero_reg;
  assign o_irq_enable = master_irq_enable_reg;
  assign o_stack_pop  = pop_reg;
  assign o_irq_taken  = taken_reg;

  // checks on the sequencer
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  chk_jump_target: assert property (
    accept && i_op == mroe_pkg::jump_op |=> o_pc == $past(i_operand))
    else $error("jump did not load target");
  chk_jump_two_cycles: assert property (
    accept && i_op == mroe_pkg::jump_op |=> !o_ready ##1 o_ready)
    else $error("jump did not take two cycles");
  chk_load_mem: assert property (
    accept && i_op == mroe_pkg::load_mem_op
    |=> !o_ready ##1 (o_ready && o_acc == $past(mem_bus.rdata)))
    else $error("memory byte not copied to accumulator");
  chk_load_literal: assert property (
    accept && i_op == mroe_pkg::load_lit_op
    |=> o_acc == $past(literal))
    else $error("literal not loaded");
  chk_store_write: assert property (
    accept && i_op == mroe_pkg::store_acc_op
    |-> mem_bus.we && mem_bus.wdata == o_acc
        && mem_bus.addr == i_operand[mroe_pkg::ADDR_W-1:0])
    else $error("store did not write accumulator");
  chk_nop_quiet: assert property (
    accept && i_op == mroe_pkg::nop_op
    |=> $stable(o_acc) && $stable(o_zero) && $stable(o_irq_enable)
        && o_pc == $past(o_pc) + mroe_pkg::PC_STEP)
    else $error("no-operation changed state");
  chk_or_memory: assert property (
    state_reg == mroe_pkg::st_mem && pend_op_reg == mroe_pkg::or_mem_op
    |=> o_acc == ($past(o_acc) | $past(mem_bus.rdata))
        && o_zero == (o_acc == mroe_pkg::DATA_ZERO))
    else $error("or with memory wrong");
  chk_or_literal: assert property (
    accept && i_op == mroe_pkg::or_lit_op
    |=> o_acc == ($past(o_acc) | $past(literal))
        && o_zero == (o_acc == mroe_pkg::DATA_ZERO))
    else $error("or with literal wrong");
  chk_or_into_mem: assert property (
    state_reg == mroe_pkg::st_mem
    && pend_op_reg == mroe_pkg::or_into_memory_op
    |-> mem_bus.we && mem_bus.wdata == (o_acc | mem_bus.rdata)
    ##1 $stable(o_acc) && o_zero == ($past(mem_bus.wdata) == 8'h00))
    else $error("or into memory wrong");
  chk_return_pop: assert property (
    accept && i_op == mroe_pkg::return_op
    |=> o_stack_pop && o_pc == $past(i_stack_top) && $stable(o_acc))
    else $error("return did not pop");
  chk_return_literal: assert property (
    accept && i_op == mroe_pkg::return_lit_op
    |=> o_stack_pop && o_pc == $past(i_stack_top)
        && o_acc == $past(literal))
    else $error("literal return wrong");
  chk_interrupt_return_op_enable: assert property (
    accept && i_op == mroe_pkg::interrupt_return_op && !i_irq_pending
    |=> o_stack_pop && o_irq_enable && o_pc == $past(i_stack_top))
    else $error("interrupt return did not enable");
  chk_interrupt_return_op_pending: assert property (
    accept && i_op == mroe_pkg::interrupt_return_op && i_irq_pending
    |=> o_irq_taken && !o_stack_pop && o_pc == mroe_pkg::IRQ_VECTOR)
    else $error("pending interrupt not serviced");
  chk_rotate_left: assert property (
    state_reg == mroe_pkg::st_mem
    && pend_op_reg == mroe_pkg::rotate_left_op
    |-> mem_bus.we && mem_bus.wdata[0] == mem_bus.rdata[7]
        && mem_bus.wdata[7:1] == mem_bus.rdata[6:0])
    else $error("rotate left wrong");
  chk_flags_kept: assert property (
    accept && i_op != mroe_pkg::or_lit_op && i_op != mroe_pkg::or_mem_op
    && i_op != mroe_pkg::or_into_memory_op
    |=> $stable(o_zero) ##1 (o_ready || $stable(o_zero)))
    else $error("zero flag changed");

  cov_jump: cover property (
    accept && i_op == mroe_pkg::jump_op ##2 o_ready);
  cov_interrupt_return_op_pending: cover property (
    accept && i_op == mroe_pkg::interrupt_return_op && i_irq_pending);
  cov_or_into: cover property (
    state_reg == mroe_pkg::st_mem
    && pend_op_reg == mroe_pkg::or_into_memory_op);
  cov_rotate: cover property (
    state_reg == mroe_pkg::st_mem
    && pend_op_reg == mroe_pkg::rotate_left_op);
endmodule

// ==== mroe_pkg.sv ====
// shared constants and types for the move/or/return execution block
package mroe_pkg;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned PC_W     = 12;
  localparam int unsigned ROT_MSB  = DATA_W - 1;
  localparam logic [PC_W-1:0]   PC_RESET   = 12'h000;
  localparam logic [PC_W-1:0]   PC_STEP    = 12'h001;
  localparam logic [PC_W-1:0]   IRQ_VECTOR = 12'h004;
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;

  // instruction codes presented by the fetch logic
  typedef enum logic [3:0] {
    nop_op              = 4'h0,
    jump_op             = 4'h1,
    load_mem_op         = 4'h2,
    load_lit_op         = 4'h3,
    store_acc_op        = 4'h4,
    or_mem_op           = 4'h5,
    or_lit_op           = 4'h6,
    or_into_memory_op   = 4'h7,
    return_op           = 4'h8,
    return_lit_op       = 4'h9,
    interrupt_return_op = 4'hA,
    rotate_left_op      = 4'hB
  } mroe_op_t;

  // sequencer states, one bit changes along each path
  typedef enum logic [1:0] {
    st_idle  = 2'h0,
    st_mem   = 2'h1,
    st_dummy = 2'h2
  } mroe_state_t;
endpackage

// ==== mroe_mem_if.sv ====
// data memory port between the sequencer and the storage array
`timescale 1ns/1ps
interface mroe_mem_if;
  logic [mroe_pkg::ADDR_W-1:0] addr;
  logic                        re;
  logic                        we;
  logic [mroe_pkg::DATA_W-1:0] wdata;
  logic [mroe_pkg::DATA_W-1:0] rdata;

  modport ctrl  (output addr, re, we, wdata, input rdata);
  modport store (input addr, re, we, wdata, output rdata);
endinterface

// ==== mroe_dmem.sv ====
// data memory array with registered read data
`timescale 1ns/1ps
module mroe_dmem #(
  parameter int unsigned DEPTH = 256
) (
  input  wire logic   i_clk_sys,
  input  wire logic   i_nrst,
  mroe_mem_if.store   bus
);
  logic [mroe_pkg::DATA_W-1:0] mem_array [DEPTH];
  logic [mroe_pkg::DATA_W-1:0] rdata_reg;
  logic [mroe_pkg::DATA_W-1:0] rdata_next;

  // read data captured on a read strobe, held otherwise
  always_comb begin
    rdata_next = rdata_reg;
    if (bus.re) begin
      rdata_next = mem_array[bus.addr];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg <= mroe_pkg::DATA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // storage array, no reset
  always_ff @(posedge i_clk_sys) begin
    if (bus.we) begin
      mem_array[bus.addr] <= bus.wdata;
    end
  end

  assign bus.rdata = rdata_reg;
endmodule

// ==== mroe_stack_model.sv ====
// call stack model on the far side of the return port
`timescale 1ns/1ps
module mroe_stack_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_push,
  input  wire logic [11:0] i_push_val,
  input  wire logic        i_pop,
  output logic [11:0]      o_top
);
  // deep enough for handler entries that leave their address stacked
  logic [11:0] stk [0:63];
  int          sp = 0;
  logic [11:0] last = 12'h000;
  // bench pushes, sequencer pulse pops the top entry, both after the edge
  always @(posedge i_clk_sys) begin
    if (i_pop && sp > 0) begin
      sp   <= sp - 1;
      last <= stk[sp-1];
    end else if (i_push) begin
      stk[sp] <= i_push_val;
      sp      <= sp + 1;
    end
  end
  // an empty stack shows no stale address
  assign o_top = (sp > 0) ? stk[sp-1] : ~last;
endmodule

// ==== tb.sv ====
// self-checking bench for the execution sequencer
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [11:0] pc;
    logic [7:0]  acc;
    logic        z;
    logic        ie;
    logic        pop;
    logic        irqt;
    int          busy;
  } mroe_note_t;
  logic clk = 0, nrst = 0, valid = 0, irq = 0, push = 0;
  logic ready, zero, ie, pop, irqt;
  mroe_pkg::mroe_op_t op = mroe_pkg::nop_op;
  logic [11:0] opd = 12'h000, push_val = 12'h000, top, pc;
  logic [7:0]  acc, m_acc, mem [0:255];
  logic [11:0] m_pc;
  logic        m_zero, m_ie, pend = 0;
  mroe_note_t  notes [$], n;
  logic [11:0] exp_stk [$];
  int errors = 0, total_checks = 0, busy = 0, cycles = 0;
  mroe_pkg::mroe_op_t r_op;
  logic [11:0] r_opd;

  mroe_exec mroe_exec_i (.i_clk_sys(clk), .i_nrst(nrst), .i_valid(valid),
    .i_op(op), .i_operand(opd), .i_irq_pending(irq), .i_stack_top(top),
    .o_ready(ready), .o_pc(pc), .o_acc(acc), .o_zero(zero),
    .o_irq_enable(ie), .o_stack_pop(pop), .o_irq_taken(irqt));
  mroe_stack_model mroe_stack_model_i (.i_clk_sys(clk), .i_push(push),
    .i_push_val(push_val), .i_pop(pop), .o_top(top));

  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen,
               exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // shadow model notes the result, then offers the instruction
  task automatic issue(input mroe_pkg::mroe_op_t o, input logic [11:0] d,
                       input logic ip);
    mroe_note_t e;
    logic [7:0] a;
    a = d[7:0];
    e.busy = 0;
    e.pop = 0;
    e.irqt = 0;
    m_pc = m_pc + mroe_pkg::PC_STEP;
    case (o)
      mroe_pkg::jump_op: begin
        m_pc = d;
        e.busy = 1;
      end
      mroe_pkg::load_mem_op: begin
        m_acc = mem[a];
        e.busy = 1;
      end
      mroe_pkg::load_lit_op: m_acc = a;
      mroe_pkg::store_acc_op: mem[a] = m_acc;
      mroe_pkg::or_mem_op, mroe_pkg::or_lit_op: begin
        m_acc = m_acc | ((o == mroe_pkg::or_lit_op) ? a : mem[a]);
        m_zero = (m_acc == 8'h00);
        e.busy = (o == mroe_pkg::or_mem_op);
      end
      mroe_pkg::or_into_memory_op: begin
        mem[a] = m_acc | mem[a];
        m_zero = (mem[a] == 8'h00);
        e.busy = 1;
      end
      mroe_pkg::return_op, mroe_pkg::return_lit_op: begin
        m_pc = exp_stk.pop_back();
        if (o == mroe_pkg::return_lit_op) m_acc = a;
        e.pop = 1;
      end
      mroe_pkg::interrupt_return_op: begin
        if (ip) begin
          m_pc = mroe_pkg::IRQ_VECTOR;
          e.irqt = 1;
          m_ie = 0;
        end else begin
          m_pc = exp_stk.pop_back();
          e.pop = 1;
          m_ie = 1;
        end
      end
      mroe_pkg::rotate_left_op: begin
        mem[a] = {mem[a][6:0], mem[a][7]};
        e.busy = 1;
      end
      default: ;
    endcase
    e.pc = m_pc;
    e.acc = m_acc;
    e.z = m_zero;
    e.ie = m_ie;
    notes.push_back(e);
    valid = 1;
    op = o;
    opd = d;
    irq = ip;
    for (int k = 0; k < 10; k++) begin
      @(posedge clk);
      if (ready === 1'b1) break;
    end
    #1;
    // the pop lands one edge late, so leave a gap after returns
    if (e.pop) begin
      valid = 0;
      @(posedge clk);
      #1;
    end
  endtask

  task automatic push_stk(input logic [11:0] v);
    valid = 0;
    push = 1;
    push_val = v;
    exp_stk.push_back(v);
    @(posedge clk);
    #1;
    push = 0;
  endtask

  task automatic end_test(input string s);
    valid = 0;
    repeat (4) @(posedge clk);
    #1;
    $display("test %s done", s);
  endtask

  // result watcher: compares the oldest note once the sequencer is idle
  initial begin
    forever begin
      @(posedge clk);
      if (pend && ready === 1'b1) begin
        if (notes.size() == 0) check(32'h0, 32'h1, "spare result");
        else begin
          n = notes.pop_front();
          check({20'h0, pc}, {20'h0, n.pc}, "pc");
          check({24'h0, acc}, {24'h0, n.acc}, "acc");
          check({31'h0, zero}, {31'h0, n.z}, "zero");
          check({31'h0, ie}, {31'h0, n.ie}, "enable");
          check({31'h0, pop}, {31'h0, n.pop}, "pop");
          check({31'h0, irqt}, {31'h0, n.irqt}, "irq entry");
          check(busy, n.busy, "busy cycles");
        end
        pend = 0;
      end else if (pend) busy++;
      if (nrst === 1'b1 && ready === 1'b1 && valid === 1'b1) begin
        pend = 1;
        busy = 0;
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(67735));
    repeat (8) @(posedge clk);
    #1;
    nrst = 1;
    m_pc = mroe_pkg::PC_RESET;
    m_acc = mroe_pkg::ACC_RESET;
    m_zero = 0;
    m_ie = 0;
    check({ready, pc, acc, zero, ie, pop, irqt}, {1'b1, 12'h000, 8'h00,
          4'h0}, "reset state");
    end_test("reset");
    // fill bytes 0..7 with random values through the accumulator
    for (int i = 0; i < 8; i++) begin
      issue(mroe_pkg::load_lit_op, 12'($urandom_range(255, 0)), 0);
      issue(mroe_pkg::store_acc_op, 12'(i), 0);
    end
    issue(mroe_pkg::load_lit_op, 12'h000, 0);
    issue(mroe_pkg::load_mem_op, 12'h003, 0);
    issue(mroe_pkg::load_mem_op, 12'h003, 0);
    end_test("moves");
    issue(mroe_pkg::load_lit_op, 12'h000, 0);
    issue(mroe_pkg::or_lit_op, 12'h000, 0);
    issue(mroe_pkg::rotate_left_op, 12'h002, 0);
    issue(mroe_pkg::load_mem_op, 12'h002, 0);
    issue(mroe_pkg::or_lit_op, 12'h080, 0);
    issue(mroe_pkg::or_mem_op, 12'h001, 0);
    issue(mroe_pkg::or_into_memory_op, 12'h005, 0);
    issue(mroe_pkg::load_mem_op, 12'h005, 0);
    end_test("or and rotate");
    issue(mroe_pkg::jump_op, 12'hFFE, 0);
    issue(mroe_pkg::jump_op, 12'h5A3, 0);
    issue(mroe_pkg::mroe_op_t'(4'hC), 12'h0FF, 0);
    issue(mroe_pkg::nop_op, 12'h000, 0);
    end_test("jump and nop");
    for (int i = 0; i < 4; i++) push_stk(12'($urandom));
    issue(mroe_pkg::return_op, 12'h000, 1);
    issue(mroe_pkg::return_lit_op, 12'h0C3, 0);
    issue(mroe_pkg::interrupt_return_op, 12'h000, 0);
    issue(mroe_pkg::interrupt_return_op, 12'h000, 1);
    issue(mroe_pkg::interrupt_return_op, 12'h000, 0);
    end_test("returns");
    for (int i = 0; i < 300; i++) begin
      r_op = mroe_pkg::mroe_op_t'($urandom_range(12, 0));
      r_opd = 12'($urandom);
      if (r_op != mroe_pkg::jump_op) r_opd[11:8] = 4'h0;
      if (r_op inside {mroe_pkg::load_mem_op, mroe_pkg::store_acc_op,
          mroe_pkg::or_mem_op, mroe_pkg::or_into_memory_op,
          mroe_pkg::rotate_left_op}) r_opd[7:3] = 5'h00;
      if (r_op inside {mroe_pkg::return_op, mroe_pkg::return_lit_op,
          mroe_pkg::interrupt_return_op}) push_stk(12'($urandom));
      issue(r_op, r_opd, 1'($urandom_range(1, 0)));
    end
    end_test("random mix");
    // a stalled sequencer leaves notes behind and must not pass
    check(32'(notes.size()), 32'h0, "results left");
    report_and_stop();
  end
endmodule
